// ---- rtl/psf_status_reg.sv ----
// Power status flag register with its management serial bus slave
// Operation
// R1 - The top bit reads one while the die is above the warning temperature.
// R2 - The top bit clears on its own once the die is back at or below it.
// R3 - Input-low flag sets on a drop below threshold after being above; holds.
// R4 - Flag zero and sense bit one mean the input never rose above threshold.
// R5 - Input-low flag clears only on a written one; a written zero keeps it.
// R6 - A clear takes effect at the next periodic refresh tick of 250 us.
// R7 - Bit 5 follows the present level of the system supply sense pin.
// R8 - Bits 4 to 1 are the regulator good levels and bit 0 the linear one.
// R9 - Writes touch no bit but the input-low flag, and there they only clear.
// R10 - Reading the register changes nothing.
`timescale 1ns/1ps
`default_nettype none
module psf_status_reg #(
    parameter int         REFRESH_CYCLES = psf_pkg::PSF_REFRESH_CYC,
    parameter logic [6:0] DEV_ADDR       = psf_pkg::PSF_DEV_ADDR
) (
    input  wire logic                            REF_CLK,
    input  wire logic                            RESET_N,
    input  wire logic                            SCL_IN,
    input  wire logic                            SDA_IN,
    output logic                                 SDA_OUT,
    output logic                                 SDA_OE_N,
    input  wire logic                            OVERTEMP_IN,
    input  wire logic                            VIN_ABOVE_UV_IN,
    input  wire logic                            SYSTEM_SUPPLY_SENSE_PIN,
    input  wire logic [psf_pkg::PSF_PG_COUNT-1:0] OUTPUT_IN_REGULATION
);
    import psf_pkg::*;

    typedef struct packed {
        psf_state_t              state;
        logic                    scl_d;
        logic                    sda_d;
        logic [3:0]              bit_cnt;
        logic [7:0]              shift;
        logic                    rw;
        logic [7:0]              ptr;
        logic                    sda_oe_n;
        logic                    sda_out;
        logic                    overtemp;
        logic                    sense;
        logic [PSF_PG_COUNT-1:0] pg;
        logic                    above_d;
        logic                    input_low_flag;
        logic                    clr_pend;
        logic [PSF_TICK_W-1:0]   tick_cnt;
    } psf_state_s_t;

    localparam logic [PSF_TICK_W-1:0] TICK_LAST =
        PSF_TICK_W'(REFRESH_CYCLES - 1);

    psf_state_s_t           s_reg;
    psf_state_s_t           s_next;
    logic [PSF_SYNC_W-1:0]  sync_q;
    logic                   scl;
    logic                   sda;
    logic                   ot_now;
    logic                   above_now;
    logic                   sense_now;
    logic [PSF_PG_COUNT-1:0] pg_now;
    logic [7:0]             status;
    logic                   scl_rise;
    logic                   scl_fall;
    logic                   start_seen;
    logic                   stop_seen;
    logic                   tick;
    logic                   uv_event;

    // Every pin and comparator input is asynchronous to REF_CLK
    psf_sync #(
        .W (PSF_SYNC_W)
    ) u_sync (
        .clk   (REF_CLK),
        .rst_n (RESET_N),
        .d     ({SCL_IN, SDA_IN, OVERTEMP_IN, VIN_ABOVE_UV_IN,
                 SYSTEM_SUPPLY_SENSE_PIN, OUTPUT_IN_REGULATION}),
        .q     (sync_q)
    );

    assign {scl, sda, ot_now, above_now, sense_now, pg_now} = sync_q;

    // Read value at a pointer; unmapped pointers read zero
    function automatic logic [7:0] read_byte(input logic [7:0] p,
                                             input logic [7:0] st);
        read_byte = (p == PSF_STATUS_OFFSET) ? st : PSF_STATUS_RESET;
    endfunction

    always_comb begin
        status = {s_reg.overtemp, s_reg.input_low_flag, s_reg.sense, s_reg.pg};
        scl_rise   = scl & ~s_reg.scl_d;
        scl_fall   = ~scl & s_reg.scl_d;
        start_seen = scl & s_reg.scl_d & s_reg.sda_d & ~sda;
        stop_seen  = scl & s_reg.scl_d & ~s_reg.sda_d & sda;
        tick       = (s_reg.tick_cnt == TICK_LAST);
        // Edge, not level, so a clear is not undone while input stays low
        uv_event   = s_reg.above_d & ~above_now; // R3

        s_next         = s_reg;
        s_next.scl_d   = scl;
        s_next.sda_d   = sda;
        s_next.sda_out = 1'b0;

        s_next.overtemp = ot_now; // R1 R2
        s_next.sense    = sense_now; // R7
        s_next.pg       = pg_now; // R8
        s_next.above_d  = above_now;

        s_next.tick_cnt = tick ? '0 : s_reg.tick_cnt + 1'b1; // R6
        if (tick && s_reg.clr_pend) begin
            s_next.input_low_flag  = 1'b0; // R6
            s_next.clr_pend = 1'b0;
        end

        case (s_reg.state)
            PSF_ADDR, PSF_PTR, PSF_WDATA: begin
                if (scl_rise) begin
                    s_next.shift   = {s_reg.shift[6:0], sda};
                    s_next.bit_cnt = s_reg.bit_cnt + 1'b1;
                end else if (scl_fall && s_reg.bit_cnt == PSF_BITS_BYTE) begin
                    s_next.bit_cnt  = '0;
                    s_next.sda_oe_n = 1'b0;
                    if (s_reg.state == PSF_ADDR) begin
                        if (s_reg.shift[7:1] == DEV_ADDR) begin
                            s_next.rw    = s_reg.shift[0];
                            s_next.state = PSF_ADDR_ACK;
                        end else begin
                            s_next.sda_oe_n = 1'b1;
                            s_next.state    = PSF_IDLE;
                        end
                    end else if (s_reg.state == PSF_PTR) begin
                        s_next.ptr   = s_reg.shift;
                        s_next.state = PSF_PTR_ACK;
                    end else begin
                        // Only a one at the flag bit acts, and only as a clear
                        if (s_reg.ptr == PSF_STATUS_OFFSET &&
                            s_reg.shift[PSF_BIT_INPUT_LOW_FLAG]) begin
                            s_next.clr_pend = 1'b1; // R5 R9
                        end
                        s_next.state = PSF_WDATA_ACK;
                    end
                end
            end
            PSF_ADDR_ACK: begin
                if (scl_fall) begin
                    s_next.bit_cnt = '0;
                    if (s_reg.rw) begin
                        // Data read leaves every bit as it was
                        s_next.shift    = read_byte(s_reg.ptr, status); // R10
                        s_next.sda_oe_n = s_next.shift[7];
                        s_next.state    = PSF_RDATA;
                    end else begin
                        s_next.sda_oe_n = 1'b1;
                        s_next.state    = PSF_PTR;
                    end
                end
            end
            PSF_PTR_ACK, PSF_WDATA_ACK: begin
                if (scl_fall) begin
                    s_next.sda_oe_n = 1'b1;
                    s_next.state    = PSF_WDATA;
                    if (s_reg.state == PSF_WDATA_ACK) begin
                        s_next.ptr = s_reg.ptr + 1'b1;
                    end
                end
            end
            PSF_RDATA: begin
                if (scl_rise) begin
                    s_next.bit_cnt = s_reg.bit_cnt + 1'b1;
                end else if (scl_fall) begin
                    if (s_reg.bit_cnt == PSF_BITS_BYTE) begin
                        s_next.sda_oe_n = 1'b1;
                        s_next.state    = PSF_RDATA_ACK;
                    end else begin
                        s_next.shift    = {s_reg.shift[6:0], 1'b0};
                        s_next.sda_oe_n = s_reg.shift[6];
                    end
                end
            end
            PSF_RDATA_ACK: begin
                if (scl_rise) begin
                    if (sda) begin
                        s_next.state = PSF_IDLE;
                    end else begin
                        s_next.bit_cnt = PSF_BITS_ACKED;
                    end
                end else if (scl_fall && s_reg.bit_cnt == PSF_BITS_ACKED) begin
                    s_next.ptr      = s_reg.ptr + 1'b1;
                    s_next.shift    = read_byte(s_reg.ptr + 1'b1, status);
                    s_next.sda_oe_n = s_next.shift[7];
                    s_next.bit_cnt  = '0;
                    s_next.state    = PSF_RDATA;
                end
            end
            PSF_IDLE: begin
                s_next.sda_oe_n = 1'b1;
            end
            default: begin
                s_next.sda_oe_n = 1'b1;
                s_next.state    = PSF_IDLE;
            end
        endcase

        // Repeated start restarts address phase from any state
        if (start_seen) begin
            s_next.state    = PSF_ADDR;
            s_next.bit_cnt  = '0;
            s_next.sda_oe_n = 1'b1;
        end else if (stop_seen) begin
            s_next.state    = PSF_IDLE;
            s_next.sda_oe_n = 1'b1;
        end

        // Set wins over a pending or same-cycle clear
        if (uv_event) begin
            s_next.input_low_flag  = 1'b1; // R3 R4
            s_next.clr_pend = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_reg          <= '0;
            s_reg.state    <= PSF_IDLE;
            s_reg.scl_d    <= 1'b1;
            s_reg.sda_d    <= 1'b1;
            s_reg.sda_oe_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign SDA_OUT  = s_reg.sda_out;
    assign SDA_OE_N = s_reg.sda_oe_n;
endmodule // psf_status_reg
`default_nettype wire

// ---- rtl/psf_pkg.sv ----
// Shared constants and types for the power status flag register
package psf_pkg;

    localparam logic [7:0] PSF_STATUS_OFFSET = 8'h1A;
    localparam int         PSF_BIT_OVERTEMP  = 7;
    localparam int         PSF_BIT_INPUT_LOW_FLAG   = 6;
    localparam int         PSF_BIT_SENSE     = 5;
    localparam int         PSF_PG_COUNT      = 5;
    localparam logic [7:0] PSF_STATUS_RESET  = 8'h00;

    // Bus device address; the value is arbitrary
    localparam logic [6:0] PSF_DEV_ADDR      = 7'h2A;

    localparam int         PSF_CLK_MHZ       = 100;
    localparam int         PSF_REFRESH_US    = 250;
    localparam int         PSF_REFRESH_CYC   = PSF_REFRESH_US * PSF_CLK_MHZ;
    localparam int         PSF_TICK_W        = 16;

    localparam logic [3:0] PSF_BITS_BYTE     = 4'h8;
    localparam logic [3:0] PSF_BITS_ACKED    = 4'h9;
    localparam int         PSF_SYNC_W        = 10;

    typedef enum logic [3:0] {
        PSF_IDLE      = 4'b0000,
        PSF_ADDR      = 4'b0001,
        PSF_ADDR_ACK  = 4'b0010,
        PSF_PTR       = 4'b0011,
        PSF_PTR_ACK   = 4'b0100,
        PSF_WDATA     = 4'b0101,
        PSF_WDATA_ACK = 4'b0110,
        PSF_RDATA     = 4'b0111,
        PSF_RDATA_ACK = 4'b1000
    } psf_state_t;

endpackage

// ---- rtl/psf_sync.sv ----
// Two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module psf_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } psf_sync_t;

    psf_sync_t s_reg;
    psf_sync_t s_next;

    always_comb begin
        s_next.meta   = d;
        s_next.stable = s_reg.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.stable;
endmodule // psf_sync
`default_nettype wire

// ---- test/psf_status_reg_monitor.sv ----
// Bus-side checker for the power status flag register
`timescale 1ns/1ps
`default_nettype none
module psf_status_reg_monitor (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_N
);
    logic idle_reg;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    // Idle means between a STOP and the next START on the pins
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) idle_reg <= 1'b1;
        else if (SCL_IN && $rose(SDA_IN)) idle_reg <= 1'b1;
        else if (SCL_IN && $fell(SDA_IN)) idle_reg <= 1'b0;
    end
    sequence s_start; SCL_IN && $fell(SDA_IN); endsequence
    sequence s_stop;  SCL_IN && $rose(SDA_IN); endsequence
    property p_out_low; SDA_OUT == 1'b0; endproperty
    a_out_low: assert property (p_out_low) else $error("sda out not low");
    // Device may only move SDA well inside the SCL low phase
    property p_oe_on_low;
        $changed(SDA_OE_N) |-> !SCL_IN && !$past(SCL_IN, 2);
    endproperty
    a_oe_on_low: assert property (p_oe_on_low) else $error("sda moved");
    property p_reset_rel; $rose(RESET_N) |-> SDA_OE_N [*3]; endproperty
    a_reset_rel: assert property (p_reset_rel) else $error("driven at reset");
    property p_start_rel; s_start |=> SDA_OE_N [*4]; endproperty
    a_start_rel: assert property (p_start_rel) else $error("driven at start");
    property p_stop_rel; s_stop |=> SDA_OE_N [*3]; endproperty
    a_stop_rel: assert property (p_stop_rel) else $error("driven at stop");
    property p_idle_rel; idle_reg |-> SDA_OE_N; endproperty
    a_idle_rel: assert property (p_idle_rel) else $error("driven when idle");
    property p_drive_hold; $fell(SDA_OE_N) |=> !SDA_OE_N [*8]; endproperty
    a_drive_hold: assert property (p_drive_hold) else $error("drive too short");
    property p_rel_hold; $rose(SDA_OE_N) |=> SDA_OE_N [*8]; endproperty
    a_rel_hold: assert property (p_rel_hold) else $error("release too short");
endmodule // psf_status_reg_monitor
bind psf_status_reg psf_status_reg_monitor i_psf_status_reg_monitor (
    .REF_CLK(REF_CLK), .RESET_N(RESET_N), .SCL_IN(SCL_IN),
    .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N));
`default_nettype wire

// ---- test/psf_host_model.sv ----
// Host bus master model, open-drain on SDA, SCL held between frames
`timescale 1ns/1ps
`default_nettype none
module psf_host_model
    import psf_pkg::*;
(
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // One bus phase; 20 cycles keeps each SCL level well over 8 cycles
    task automatic ph(input logic l1, l2, c, output logic r);
        repeat (5) @(negedge clk);
        sda_low = l1;
        repeat (5) @(negedge clk);
        scl = 1'b1;
        repeat (5) @(negedge clk);
        r = sda;
        sda_low = l2;
        repeat (5) @(negedge clk);
        scl = c;
    endtask
    task automatic xfer(input logic [7:0] d, input logic m,
                        output logic [7:0] q, output logic k);
        for (int i = 7; i >= 0; i--) ph(!d[i], !d[i], 1'b0, q[i]);
        ph(!m, !m, 1'b0, k);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d,
                      output logic ak);
        logic [7:0] q;
        logic       k;
        ph(1'b0, 1'b1, 1'b0, k);
        xfer({a, 1'b0}, 1'b1, q, ak);
        xfer(PSF_STATUS_OFFSET, 1'b1, q, k);
        xfer(d, 1'b1, q, k);
        ph(1'b1, 1'b0, 1'b1, k);
    endtask
    task automatic rd(output logic [7:0] d);
        logic [7:0] q;
        logic       k;
        ph(1'b0, 1'b1, 1'b0, k);
        xfer({PSF_DEV_ADDR, 1'b0}, 1'b1, q, k);
        xfer(PSF_STATUS_OFFSET, 1'b1, q, k);
        ph(1'b0, 1'b1, 1'b0, k);
        xfer({PSF_DEV_ADDR, 1'b1}, 1'b1, q, k);
        xfer(8'hFF, 1'b1, d, k);
        ph(1'b1, 1'b0, 1'b1, k);
    endtask
    // Two-byte read: host acks the first byte so the pointer moves on
    task automatic rd2(output logic [7:0] d0, output logic [7:0] d1);
        logic [7:0] q;
        logic       k;
        ph(1'b0, 1'b1, 1'b0, k);
        xfer({PSF_DEV_ADDR, 1'b0}, 1'b1, q, k);
        xfer(PSF_STATUS_OFFSET, 1'b1, q, k);
        ph(1'b0, 1'b1, 1'b0, k);
        xfer({PSF_DEV_ADDR, 1'b1}, 1'b1, q, k);
        xfer(8'hFF, 1'b0, d0, k);
        xfer(8'hFF, 1'b1, d1, k);
        ph(1'b1, 1'b0, 1'b1, k);
    endtask
endmodule // psf_host_model
`default_nettype wire

// ---- test/psf_status_reg_tb_top.sv ----
// Self-checking bench for the power status flag register
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
    $display("MISMATCH %s exp %h got %h", n, e, s); errors++; end end
module psf_status_reg_tb_top;
    import psf_pkg::*;
    logic       clk, rst_n, ot, vin, sense, scl, h_low, oe_n;
    logic [4:0] good;
    wire logic  sda;
    int         errors = 0;
    int         n_checks = 0;
    int         cyc = 0;
    // Pull-up: the wire is low whenever either party pulls it
    assign sda = !h_low && oe_n;
    psf_status_reg #(.REFRESH_CYCLES(16)) i_psf_status_reg (
        .REF_CLK(clk), .RESET_N(rst_n), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(), .SDA_OE_N(oe_n), .OVERTEMP_IN(ot),
        .VIN_ABOVE_UV_IN(vin), .SYSTEM_SUPPLY_SENSE_PIN(sense),
        .OUTPUT_IN_REGULATION(good));
    psf_host_model i_psf_host_model (
        .clk(clk), .sda(sda), .scl(scl), .sda_low(h_low));
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_never_above();
        logic [7:0] d;
        i_psf_host_model.rd(d);
        `CHK("never_above", 8'h20, d)
    endtask
    task automatic t_live();
        logic [7:0] pat [4] = '{8'h9F, 8'hA0, 8'h15, 8'h0A};
        logic [7:0] d;
        foreach (pat[i]) begin
            @(negedge clk);
            {ot, sense, good} = {pat[i][7], pat[i][5], pat[i][4:0]};
            i_psf_host_model.rd(d);
            `CHK("live_bits", pat[i], d)
        end
    endtask
    task automatic t_uv();
        logic [7:0] d;
        logic       ak;
        @(negedge clk);
        vin = 1'b1;
        repeat (6) @(negedge clk);
        vin = 1'b0;
        i_psf_host_model.rd(d);
        `CHK("uv_set", 8'h4A, d)
        i_psf_host_model.rd(d);
        `CHK("uv_after_read", 8'h4A, d)
        i_psf_host_model.wr(PSF_DEV_ADDR, 8'hBF, ak);
        `CHK("ack", 1'b0, ak)
        i_psf_host_model.rd(d);
        `CHK("uv_write_zero", 8'h4A, d)
        i_psf_host_model.wr(PSF_DEV_ADDR ^ 7'h01, 8'h40, ak);
        `CHK("nack", 1'b1, ak)
        i_psf_host_model.rd(d);
        `CHK("uv_other_addr", 8'h4A, d)
        i_psf_host_model.wr(PSF_DEV_ADDR, 8'h40, ak);
        // Refresh tick is 16 cycles here, so 20 always covers it
        repeat (20) @(negedge clk);
        i_psf_host_model.rd(d);
        `CHK("uv_cleared", 8'h0A, d)
    endtask
    // Acked read runs on to the next pointer, which is unmapped
    task automatic t_burst();
        logic [7:0] d0;
        logic [7:0] d1;
        i_psf_host_model.rd2(d0, d1);
        `CHK("burst_first", 8'h0A, d0)
        `CHK("burst_unmapped", 8'h00, d1)
    endtask
    // Flag set again after a clear, then lost across a mid-run reset
    task automatic t_reset();
        logic [7:0] d;
        @(negedge clk);
        vin = 1'b1;
        repeat (6) @(negedge clk);
        vin = 1'b0;
        i_psf_host_model.rd(d);
        `CHK("uv_set_again", 8'h4A, d)
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        i_psf_host_model.rd(d);
        `CHK("uv_after_reset", 8'h0A, d)
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {rst_n, ot, vin, sense, good} = {4'h1, 5'h00};
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        t_never_above();
        t_live();
        t_uv();
        t_burst();
        t_reset();
        complete_run();
    end
    // About 12k cycles of traffic; the ceiling leaves ample margin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            complete_run();
        end
    end
endmodule // psf_status_reg_tb_top
`default_nettype wire
